// ### acs_params.svh
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
// mode field codes
`define ACS_MODE_CONT      3'h0
`define ACS_MODE_IDLE      3'h2
`define ACS_MODE_INT_ZERO  3'h4
`define ACS_MODE_SYS_ZERO  3'h6
`define ACS_MODE_SYS_FULL  3'h7
// conversion cycles per calibration
`define ACS_CAL_CYCLES     2
// coefficient reset values
`define ACS_OFFSET_RST     24'h800000
`define ACS_GAIN_RST       24'h555555
// unity gain point of the gain coefficient
`define ACS_GAIN_SHIFT     22
`endif

// ### acs_pkg.sv
`default_nettype none
package acs_pkg;
   typedef logic [2:0] acs_mode_t;
   typedef enum logic [1:0]
   {
      ACS_IDLE = 2'h0,
      ACS_CONV = 2'h1,
      ACS_CAL  = 2'h3,
      ACS_DONE = 2'h2
   } acs_state_t;
endpackage : acs_pkg
`default_nettype wire

// ### acs_if.sv
`timescale 1ns/1ps
`default_nettype none
// host to converter link
interface acs_if;
   logic             mode_wr;      // host writes mode field
   acs_pkg::acs_mode_t operating_mode_select;
   logic             cs_n;         // chip select, active low
   logic             dout_rdy_n;   // combined out/ready level
   logic             rdy_flag;     // ready status flag
   logic [23:0]      data;         // corrected result
   modport dev  (input mode_wr, operating_mode_select, cs_n,
                 output dout_rdy_n, rdy_flag, data);
   modport host (output mode_wr, operating_mode_select, cs_n,
                 input dout_rdy_n, rdy_flag, data);
endinterface : acs_if
`default_nettype wire

// ### acs_corrector.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
// offset subtract then gain multiply
module acs_corrector #(parameter int W = 24)
(
   input  wire logic [W-1:0] raw,      // raw result
   input  wire logic [W-1:0] offset,   // offset coefficient
   input  wire logic [W-1:0] gain,     // gain coefficient
   output logic      [W-1:0] result    // corrected result
);
   logic signed [W:0]     diff;
   logic signed [2*W+1:0] prod;
   logic signed [2*W+1:0] scaled;
   // subtract first, then scale
   always_comb
   begin
      diff   = $signed({1'b0, raw}) - $signed({1'b0, offset}); // R3
      prod   = diff * $signed({1'b0, gain}); // R3
      scaled = (prod >>> `ACS_GAIN_SHIFT) + $signed((2*W+2)'(1) << (W-1));
      if (scaled < 0)
         result = '0;
      else if (scaled > $signed((2*W+2)'({W{1'b1}})))
         result = '1;
      else
         result = scaled[W-1:0];
   end
endmodule : acs_corrector
`default_nettype wire

// ### acs_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
// How it works
// R1: three calibration modes via mode field
// R2: results corrected before data register
// R3: subtract offset, then multiply by gain
// R4: host writes code into mode field
// R5: ready pin high when calibration starts
// R6: finish: store, flag, pin low, idle; pin stays high while chip select is high
// R7: internal zero uses internal zero input
// R8: host applies system voltage beforehand
// R9: host calibrates zero before full-scale
// R10: host polls flag or watches pin
// R11: offset calibration takes two conversions
// R12: full-scale calibration takes two conversions
// R13: full-scale result stored in gain register
// R14: coefficients hold until recalibration or reset
module acs_device #(parameter int W = 24)
(
   input  wire logic         clk_sys,     // system clock
   input  wire logic         rst,         // async reset
   input  wire logic         ce,          // clock enable
   acs_if.dev                link,        // host link
   input  wire logic [W-1:0] adc_pin,     // modulator code from pins
   input  wire logic [W-1:0] adc_zero,    // modulator code, zero input
   input  wire logic         conv_done,   // conversion cycle end pulse
   output logic              zero_sel,    // internal zero switch
   output logic [W-1:0]      offset_coef, // offset coefficient
   output logic [W-1:0]      gain_coef    // gain coefficient
);
   import acs_pkg::*;

   // ****
   // state and internal signals
   // ****
   // whole sequencer state, registered as one word
   typedef struct packed
   {
      acs_state_t   st;       // sequencer state
      acs_mode_t    mode;     // mode code in force
      logic [1:0]   cnt;      // conversion ends seen
      logic [W-1:0] off;      // offset coefficient
      logic [W-1:0] gn;       // gain coefficient
      logic [W-1:0] data;     // corrected result word
      logic         rdy;      // ready status flag
      logic         busy_pin; // pin level before gating
   } acs_dev_state_t;
   acs_dev_state_t s;
   acs_dev_state_t next_s;
   logic [W-1:0]   raw;       // code under conversion
   logic [W-1:0]   corr;      // corrected code
   logic [W-1:0]   gain_meas; // gain measured now
   logic [2*W:0]   gain_num;  // full-scale span, scaled up
   logic [2*W:0]   gain_quo;  // gain before clipping
   logic           is_cal;    // written code starts a calibration

   // ****
   // input selection and mode decode
   // ****
   // zero input for internal zero calibration, pins otherwise
   assign raw = (s.mode == `ACS_MODE_INT_ZERO) ? adc_zero : adc_pin; // R7
   // codes that start a calibration
   always_comb
   begin
      case (link.operating_mode_select)
         `ACS_MODE_INT_ZERO: is_cal = 1'b1; // R1
         `ACS_MODE_SYS_ZERO: is_cal = 1'b1; // R1
         `ACS_MODE_SYS_FULL: is_cal = 1'b1; // R1
         default:            is_cal = 1'b0;
      endcase
   end

   // ****
   // coefficient measurement
   // ****
   // gain that maps offset-removed full input to full scale; wide to keep the span
   always_comb
   begin
      gain_num  = '0;
      gain_quo  = '0;
      gain_meas = s.gn;
      if (raw > s.off)
      begin
         gain_num = (2*W+1)'({W{1'b1}}) << (`ACS_GAIN_SHIFT - 1);
         gain_quo = gain_num / (2*W+1)'(raw - s.off);
         if (gain_quo > (2*W+1)'({W{1'b1}}))
            gain_meas = '1; // clip an oversized gain
         else
            gain_meas = gain_quo[W-1:0];
      end
   end

   // ****
   // result correction
   // ****
   // offset removed first, then gain applied
   acs_corrector #(.W(W)) u_corr
   (
      .raw    (raw),
      .offset (s.off),
      .gain   (s.gn),
      .result (corr)
   );

   // ****
   // next state
   // ****
   // sequencer and result update
   always_comb
   begin
      next_s = s;
      // a mode write overrides the running sequence
      if (link.mode_wr)
      begin
         next_s.mode = link.operating_mode_select;
         if (is_cal)
         begin
            next_s.st       = ACS_CAL;
            next_s.cnt      = 2'h0;
            next_s.rdy      = 1'b0;
            next_s.busy_pin = 1'b1; // R5
         end
         else if (link.operating_mode_select == `ACS_MODE_CONT)
            next_s.st = ACS_CONV;
         else
            next_s.st = ACS_IDLE;
      end
      else
      begin
         case (s.st)
            ACS_IDLE:
            begin
               next_s.st = ACS_IDLE; // conversion ends ignored
            end
            ACS_CONV:
            begin
               // correct each finished conversion
               if (conv_done)
               begin
                  next_s.data     = corr; // R2
                  next_s.rdy      = 1'b1;
                  next_s.busy_pin = 1'b0;
               end
            end
            ACS_CAL:
            begin
               // count conversion ends, then finish
               if (conv_done)
               begin
                  next_s.cnt = s.cnt + 2'h1;
                  if (s.cnt == 2'(`ACS_CAL_CYCLES - 1)) // R11 R12
                     next_s.st = ACS_DONE;
               end
            end
            ACS_DONE:
            begin
               // store the matching coefficient
               if (s.mode == `ACS_MODE_SYS_FULL)
                  next_s.gn = gain_meas; // R13 R6
               else
                  next_s.off = raw; // R6
               next_s.rdy      = 1'b1; // R6
               next_s.busy_pin = 1'b0; // R6
               next_s.mode     = `ACS_MODE_IDLE;
               next_s.st       = ACS_IDLE; // R6
            end
            default:
            begin
               next_s.st = ACS_IDLE;
            end
         endcase
      end
   end

   // ****
   // state register
   // ****
   // registered state, coefficients held otherwise
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         // coefficients back to their defaults
         s.st       <= ACS_IDLE;
         s.mode     <= `ACS_MODE_IDLE;
         s.cnt      <= 2'h0;
         s.off      <= W'(`ACS_OFFSET_RST); // R14
         s.gn       <= W'(`ACS_GAIN_RST); // R14
         s.data     <= '0;
         s.rdy      <= 1'b0;
         s.busy_pin <= 1'b1;
      end
      else if (ce)
         s <= next_s;
   end

   // ****
   // outputs
   // ****
   // pin shows ready only under chip select
   assign link.dout_rdy_n = link.cs_n ? 1'b1 : s.busy_pin; // R6
   assign link.rdy_flag   = s.rdy;
   assign link.data       = s.data;
   // converter side
   assign zero_sel        = (s.mode == `ACS_MODE_INT_ZERO); // R7
   assign offset_coef     = s.off;
   assign gain_coef       = s.gn;

endmodule : acs_device
`default_nettype wire

// ### acs_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
// host side: issues calibrations, waits for ready
module acs_host
(
   input  wire logic        clk_sys,   // system clock
   input  wire logic        rst,       // async reset
   input  wire logic        ce,        // clock enable
   acs_if.host              link,      // device link
   input  wire logic        start,     // start pulse
   input  wire acs_pkg::acs_mode_t mode, // requested code
   input  wire logic        use_pin,   // watch pin, else poll flag
   output logic             busy,      // mode written, waiting for ready
   output logic             done,      // one-cycle completion pulse
   output logic [23:0]      result     // last data word
);
   import acs_pkg::*;
   typedef struct packed
   {
      logic      busy;
      logic      wr;
      logic      done;
      acs_mode_t md;
      logic [2:0] sync;
      logic [23:0] res;
   } acs_host_state_t;
   acs_host_state_t s, next_s;
   logic finished;
   // three-stage sampling of the pin level, stages two and three agree
   assign finished = use_pin ? (~s.sync[1] & ~s.sync[2]) : link.rdy_flag; // R10
   always_comb
   begin
      next_s      = s;
      next_s.wr   = 1'b0;
      next_s.done = 1'b0;
      next_s.sync = {s.sync[1:0], link.dout_rdy_n};
      // system voltage assumed applied before start; zero before full
      if (start && !s.busy)
      begin
         next_s.md   = mode; // R4 R8 R9
         next_s.wr   = 1'b1;
         next_s.busy = 1'b1;
         next_s.sync = 3'h7;
      end
      else if (s.busy && !s.wr && finished)
      begin
         next_s.busy = 1'b0;
         next_s.done = 1'b1;
         next_s.res  = link.data;
      end
   end
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s.busy <= 1'b0;
         s.wr   <= 1'b0;
         s.done <= 1'b0;
         s.md   <= `ACS_MODE_IDLE;
         s.sync <= 3'h7;
         s.res  <= 24'h000000;
      end
      else if (ce)
         s <= next_s;
   end
   assign link.mode_wr               = s.wr;
   assign link.operating_mode_select = s.md;
   assign link.cs_n                  = ~use_pin; // deselect while polling the flag
   assign busy                       = s.busy;
   assign done                       = s.done;
   assign result                     = s.res;
endmodule : acs_host
`default_nettype wire

// ### acs_cal_properties.sv
`timescale 1ns/1ps
`default_nettype none
module acs_cal_checker
(
   input wire logic               clk_sys,               // clock
   input wire logic               rst,                   // reset
   input wire logic               mode_wr,               // mode write
   input wire acs_pkg::acs_mode_t operating_mode_select, // mode code
   input wire logic               cs_n,                  // chip select
   input wire logic               dout_rdy_n,            // ready pin
   input wire logic               rdy_flag,              // ready flag
   input wire logic [23:0]        data                   // result
);
   import acs_pkg::*;
   // ****
   // calibration checks
   // ****
   logic cal;
   // calibration code written
   assign cal = mode_wr && operating_mode_select inside {3'h4, 3'h6, 3'h7};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_start_pin_high: assert property (cal |=> dout_rdy_n && !rdy_flag)
      else $error("pin not high at start");
   chk_cs_gate: assert property (cs_n |-> dout_rdy_n)
      else $error("pin low while deselected");
   chk_pin_needs_flag: assert property (!dout_rdy_n |-> rdy_flag)
      else $error("pin low without flag");
   chk_ready_pin_low: assert property ($rose(rdy_flag) && !cs_n |-> !dout_rdy_n)
      else $error("pin not low at ready");
   chk_flag_hold: assert property (rdy_flag && !mode_wr |=> rdy_flag)
      else $error("flag dropped");
   chk_flag_fall_cause: assert property ($fell(rdy_flag) |-> $past(cal))
      else $error("flag fell without write");
   chk_cal_bound: assert property (cal |-> ##[2:60] rdy_flag)
      else $error("calibration too long");
   chk_no_early_end: assert property (cal |=> !rdy_flag [*8])
      else $error("calibration too short");
   cover property (cal && operating_mode_select == 3'h4);
   cover property (cal && operating_mode_select == 3'h7);
   cover property ($rose(rdy_flag));
endmodule : acs_cal_checker
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import acs_pkg::*;
   logic        clk_sys = 0;
   logic        rst = 1;
   logic        start = 0;
   acs_mode_t   mode = 3'h0;
   logic        use_pin = 0;
   logic        conv_done = 0;
   logic [23:0] adc_pin = 24'h000000;
   logic [23:0] adc_zero = 24'h800100;
   logic        busy, done, zero_sel;
   logic [23:0] result, offset_coef, gain_coef;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          cc = 0;
   acs_if lnk();
   acs_device i_acs_device (.clk_sys, .rst, .ce(1'b1), .link(lnk), .adc_pin, .adc_zero,
      .conv_done, .zero_sel, .offset_coef, .gain_coef);
   acs_host i_acs_host (.clk_sys, .rst, .ce(1'b1), .link(lnk), .start, .mode, .use_pin,
      .busy, .done, .result);
   acs_cal_checker i_acs_cal_checker (.clk_sys, .rst, .mode_wr(lnk.mode_wr),
      .operating_mode_select(lnk.operating_mode_select), .cs_n(lnk.cs_n),
      .dout_rdy_n(lnk.dout_rdy_n), .rdy_flag(lnk.rdy_flag), .data(lnk.data));
   // ****
   // clock and conversion pulses
   // ****
   always #2.5 clk_sys = ~clk_sys;
   // end of conversion every 10 clocks
   always @(posedge clk_sys)
   begin
      #1;
      cc = (cc + 1) % 10;
      conv_done = (cc == 0);
   end
   // ****
   // tasks
   // ****
   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic results;
      if (miscompares == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   // one calibration through the host, watching pin or flag
   task automatic cal(input acs_mode_t m, input logic pin);
      int i;
      mode = m;
      use_pin = pin;
      start = 1;
      @(posedge clk_sys);
      #1 start = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      check("pin_busy", 24'h1, {23'h0, lnk.dout_rdy_n});
      check("zero_sel", {23'h0, m == 3'h4}, {23'h0, zero_sel});
      check("busy", 24'h1, {23'h0, busy});
      for (i = 0; i < 100 && done !== 1'b1; i++)
      begin
         @(posedge clk_sys);
         #1;
      end
      if (done !== 1'b1)
      begin
         miscompares++;
         results();
      end
      check("rdy_flag", 24'h1, {23'h0, lnk.rdy_flag});
      check("pin_ready", {23'h0, !pin}, {23'h0, lnk.dout_rdy_n});
      check("idle_busy", 24'h0, {23'h0, busy});
   endtask : cal
   task automatic t_int_zero;
      adc_pin = 24'h123456;
      cal(3'h4, 1'b1);
      check("offset", 24'h800100, offset_coef);
   endtask : t_int_zero
   task automatic t_sys_zero;
      adc_pin = 24'h800040;
      cal(3'h6, 1'b0);
      check("offset", 24'h800040, offset_coef);
   endtask : t_sys_zero
   task automatic t_sys_full;
      adc_pin = 24'hc00040;
      cal(3'h7, 1'b1);
      check("gain", 24'h7fffff, gain_coef);
      check("offset_kept", 24'h800040, offset_coef);
   endtask : t_sys_full
   // continuous conversion corrected by both coefficients
   task automatic t_convert;
      int i;
      adc_pin = 24'h900040;
      mode = 3'h0;
      start = 1;
      @(posedge clk_sys);
      #1 start = 0;
      for (i = 0; i < 40 && lnk.data !== 24'h9fffff; i++)
      begin
         @(posedge clk_sys);
         #1;
      end
      check("data", 24'h9fffff, lnk.data);
   endtask : t_convert
   // idle code stops conversions; host takes the standing word
   task automatic t_idle;
      mode = 3'h2;
      use_pin = 1'b1;
      start = 1;
      @(posedge clk_sys);
      #1 start = 0;
      @(posedge clk_sys);
      #1 adc_pin = 24'h800040;
      repeat (25) @(posedge clk_sys);
      #1;
      check("data_held", 24'h9fffff, lnk.data);
      check("host_result", 24'h9fffff, result);
      check("idle_rdy", 24'h1, {23'h0, lnk.rdy_flag});
      check("offset_held", 24'h800040, offset_coef);
   endtask : t_idle
   initial
   begin
      repeat (8) @(posedge clk_sys);
      #1 rst = 0;
      check("offset_rst", 24'h800000, offset_coef);
      check("gain_rst", 24'h555555, gain_coef);
      t_int_zero();
      t_sys_zero();
      t_sys_full();
      t_convert();
      t_idle();
      results();
   end
endmodule : tb
`default_nettype wire
